// [eep_consts.svh]
// Purpose: shared constants of the two-wire memory front end
// Assumes: system clock of 250 MHz
// Notes:   times kept in their own unit, cycle counts derived here
`ifndef EEP_CONSTS_SVH
`define EEP_CONSTS_SVH

`define EEP_CLK_MHZ        250
// fixed upper address bits, one/zero pattern shared by related parts
`define EEP_ADDR_PREFIX    5'b10100
`define EEP_PREFIX_W       5
`define EEP_WORD_W         8
`define EEP_FRAME_BITS     9
`define EEP_RECOVER_CLKS   9
// write cycle limits in ms, low supply grade and the others
`define EEP_TWR_LOW_MS     20
`define EEP_TWR_STD_MS     10
`define EEP_TWR_LOW_CYC    (`EEP_TWR_LOW_MS * 1000 * `EEP_CLK_MHZ)
`define EEP_TWR_STD_CYC    (`EEP_TWR_STD_MS * 1000 * `EEP_CLK_MHZ)
`define EEP_TWR_CNT_W      23
// words of a write sequence needed before a write cycle runs
`define EEP_WR_WORDS_MIN   2'h3
// host serial clock period in ns and its quarter in clock cycles
`define EEP_SCL_PERIOD_NS  4000
`define EEP_SCL_QTR_CYC    (`EEP_SCL_PERIOD_NS * `EEP_CLK_MHZ / 4000)
`define EEP_QTR_CNT_W      16

`endif

// [eep_pkg.sv]
// Purpose: types of the two-wire memory front end
// Assumes: eep_consts.svh on the include path
// Notes:   state structs of both ends live here
`include "eep_consts.svh"

package eep_pkg;

  typedef enum logic [2:0] {
    EEP_ST_STANDBY = 3'b000,
    EEP_ST_ADDR    = 3'b001,
    EEP_ST_ACK     = 3'b010,
    EEP_ST_WDATA   = 3'b011,
    EEP_ST_RDATA   = 3'b100,
    EEP_ST_RACK    = 3'b101,
    EEP_ST_WCYCLE  = 3'b110
  } eep_dev_state_type;

  typedef enum logic [2:0] {
    EEP_H_IDLE    = 3'b000,
    EEP_H_START   = 3'b001,
    EEP_H_STOP    = 3'b010,
    EEP_H_BYTE    = 3'b011,
    EEP_H_RECOVER = 3'b100
  } eep_host_state_type;

  typedef enum logic [2:0] {
    EEP_CMD_START   = 3'b000,
    EEP_CMD_STOP    = 3'b001,
    EEP_CMD_WRITE   = 3'b010,
    EEP_CMD_READ    = 3'b011,
    EEP_CMD_RECOVER = 3'b100
  } eep_cmd_type;

  typedef struct packed {
    eep_dev_state_type        st;
    logic                     scl_q;
    logic                     sda_q;
    logic [3:0]               cnt;
    logic [`EEP_WORD_W-1:0]   sh;
    logic                     rw;
    logic [1:0]               words;
    logic [1:0]               sel;
    logic                     sel_ok;
    logic                     sda_oe;
    logic [`EEP_TWR_CNT_W-1:0] wr_cnt;
    logic                     rx_valid;
    logic [`EEP_WORD_W-1:0]   rx_data;
    logic                     tx_take;
  } eep_dev_reg_type;

  typedef struct packed {
    eep_host_state_type         st;
    logic [1:0]                 phase;
    logic [`EEP_QTR_CNT_W-1:0]  qcnt;
    logic [3:0]                 cnt;
    logic [`EEP_FRAME_BITS-1:0] sh;
    logic [`EEP_FRAME_BITS-1:0] rx;
    logic                       scl;
    logic                       sda_oe;
    logic                       rsp_valid;
    logic [`EEP_WORD_W-1:0]     rsp_data;
    logic                       rsp_nack;
  } eep_host_reg_type;

endpackage : eep_pkg

// [eep_bus_if.sv]
// Purpose: two-wire bus between controller and memory front end
// Assumes: open-drain data line with a pull-up
// Notes:   the wire level is resolved here from the enables
`timescale 1ns/1ps
`default_nettype none

interface eep_bus_if;
  logic scl;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic sda_in;

  // pull-up wins unless an enabled driver pulls low
  assign sda_in = ~((sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o));

  modport host (
    output scl,
    output sda_host_o,
    output sda_host_oe,
    input  sda_in
  );

  modport dev (
    input  scl,
    output sda_dev_o,
    output sda_dev_oe,
    input  sda_in
  );
endinterface : eep_bus_if

`default_nettype wire

// [eep_pin_filter.sv]
// Purpose: three-stage synchroniser with agreement filter per bit
// Assumes: inputs asynchronous to clk_sys
// Notes:   output moves only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module eep_pin_filter #(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic         ce,
  // pins in, filtered levels out
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } eep_filt_type;

  eep_filt_type r;
  eep_filt_type n;
  logic [W-1:0] lvl_nxt;

  // idle bus is high, so every stage resets high
  always_comb begin
    n    = r;
    n.s1 = pin_in;
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.lvl = lvl_nxt;
  end

  // per-bit agreement kept out of the state process: one writer of n
  for (genvar i = 0; i < W; i++) begin : g_bit
    assign lvl_nxt[i] = (r.s2[i] == r.s3[i]) ? r.s3[i] : r.lvl[i];
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      r <= '1;
    end else if (ce) begin
      r <= n;
    end
  end

  assign level = r.lvl;

endmodule : eep_pin_filter

`default_nettype wire

// [eep_dev_end.sv]
// Purpose: memory-side front end of the two-wire bus
// Assumes: host drives scl; array and address logic sit outside
// Notes:   all bus timing recovered by oversampling on clk_sys
//
// Bus rules of the document
// RULE1 - transmitter changes data only while clock low
// RULE2 - data change with clock high is condition
// RULE3 - data falling, clock high, means start
// RULE4 - controller sends start before every command
// RULE5 - data rising, clock high, means stop
// RULE6 - stop after read enters standby
// RULE7 - eight-bit words, ack low in ninth clock
// RULE8 - standby at power-up and after finished stop
// RULE9 - controller recovers with nine clocks then start; host end starts once data reads high, none if still low after nine
// RULE10 - address word follows start, enables device
// RULE11 - five top bits match fixed prefix
// RULE12 - next two bits match select straps
// RULE13 - write cycle lasts 20 or 10 ms
// RULE14 - eighth address bit high reads, low writes
// RULE15 - match acks low, mismatch returns standby
// RULE16 - floating select straps count as low
// RULE17 - during write cycle ignore bus entirely
// RULE18 - data line only pulled low, else released
// RULE19 - address prefix held as design constant
`timescale 1ns/1ps
`default_nettype none

module eep_dev_end
  import eep_pkg::*;
#(
  parameter int unsigned TWR_LOW_CYC = `EEP_TWR_LOW_CYC,
  parameter int unsigned TWR_STD_CYC = `EEP_TWR_STD_CYC
) (
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   resetn,
  input  wire logic                   ce,
  // two-wire bus
  eep_bus_if.dev                      bus,
  // straps
  input  wire logic                   select_pin_high,
  input  wire logic                   select_pin_low,
  input  wire logic                   low_supply_grade,
  // received words
  output logic                        rx_valid,
  output logic      [`EEP_WORD_W-1:0] rx_data,
  // words to send
  input  wire logic [`EEP_WORD_W-1:0] tx_data,
  output logic                        tx_take,
  // status
  output logic                        standby,
  output logic                        write_busy
);

  eep_dev_reg_type r;
  eep_dev_reg_type n;
  logic [1:0]      lvl;
  logic            scl;
  logic            sda;
  logic            rise;
  logic            fall;
  logic            start_c;
  logic            stop_c;
  logic            match;

  eep_pin_filter #(
    .W (2)
  ) u_filt (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .ce      (ce),
    .pin_in  ({bus.scl, bus.sda_in}),
    .level   (lvl)
  );

  assign scl = lvl[1];
  assign sda = lvl[0];

  // edges and conditions from filtered levels
  assign rise    = scl & ~r.scl_q;
  assign fall    = ~scl & r.scl_q;
  assign start_c = scl & r.scl_q & r.sda_q & ~sda; // see RULE2 see RULE3
  assign stop_c  = scl & r.scl_q & ~r.sda_q & sda; // see RULE2 see RULE5

  // sh holds the address word once eight bits are in
  assign match = (r.sh[7:3] == `EEP_ADDR_PREFIX)   // see RULE11 see RULE19
               & (r.sh[2:1] == r.sel);             // see RULE12

  always_comb begin
    n          = r;
    n.scl_q    = scl;
    n.sda_q    = sda;
    n.rx_valid = 1'b0;
    n.tx_take  = 1'b0;
    // straps caught once after reset; anything not driven high is low
    if (!r.sel_ok) begin
      n.sel    = {select_pin_high === 1'b1,
                  select_pin_low === 1'b1};        // see RULE16
      n.sel_ok = 1'b1;
    end
    if (r.st == EEP_ST_WCYCLE) begin
      // bus deaf until the timed cycle ends
      n.sda_oe = 1'b0;                             // see RULE17
      if (r.wr_cnt == '0) begin
        n.st = EEP_ST_STANDBY;                     // see RULE8
      end else begin
        n.wr_cnt = r.wr_cnt - 1'b1;                // see RULE13
      end
    end else if (start_c) begin
      n.st     = EEP_ST_ADDR;                      // see RULE10
      n.cnt    = 4'h0;
      n.words  = 2'h0;
      n.sda_oe = 1'b0;
    end else if (stop_c) begin
      n.sda_oe = 1'b0;
      if (!r.rw && r.words == `EEP_WR_WORDS_MIN) begin
        n.st     = EEP_ST_WCYCLE;
        n.wr_cnt = low_supply_grade                // see RULE13
                 ? `EEP_TWR_CNT_W'(TWR_LOW_CYC - 1)
                 : `EEP_TWR_CNT_W'(TWR_STD_CYC - 1);
      end else begin
        n.st = EEP_ST_STANDBY;                     // see RULE6 see RULE8
      end
    end else begin
      case (r.st)
        EEP_ST_ADDR, EEP_ST_WDATA: begin
          if (rise) begin
            // sampled on rising clock only
            n.sh  = {r.sh[6:0], sda};              // see RULE1 see RULE7
            n.cnt = r.cnt + 4'h1;
          end else if (fall && r.cnt == 4'h8) begin
            n.cnt = 4'h0;
            if (r.st == EEP_ST_WDATA) begin
              n.rx_valid = 1'b1;
              n.rx_data  = r.sh;
              n.st       = EEP_ST_ACK;
              n.sda_oe   = 1'b1;                   // see RULE7
              if (r.words != `EEP_WR_WORDS_MIN) begin
                n.words = r.words + 2'h1;
              end
            end else if (match) begin
              n.rw     = r.sh[0];                  // see RULE14
              n.st     = EEP_ST_ACK;
              n.sda_oe = 1'b1;                     // see RULE15
            end else begin
              n.st = EEP_ST_STANDBY;               // see RULE15
            end
          end
        end
        EEP_ST_ACK: begin
          if (fall) begin
            n.cnt    = 4'h0;
            n.sda_oe = 1'b0;                       // see RULE18
            if (r.rw) begin
              n.sh      = tx_data;
              n.tx_take = 1'b1;
              n.sda_oe  = ~tx_data[7];             // see RULE18
              n.st      = EEP_ST_RDATA;
            end else begin
              n.st = EEP_ST_WDATA;
            end
          end
        end
        EEP_ST_RDATA: begin
          // next bit changes on the falling clock
          if (fall) begin
            n.cnt = r.cnt + 4'h1;
            if (r.cnt == 4'h7) begin
              n.sda_oe = 1'b0;                     // see RULE18
              n.st     = EEP_ST_RACK;
            end else begin
              n.sh     = {r.sh[6:0], 1'b0};
              n.sda_oe = ~r.sh[6];                 // see RULE1
            end
          end
        end
        EEP_ST_RACK: begin
          if (rise && sda) begin
            // no ack from controller: standby at once, before its stop
            n.st = EEP_ST_STANDBY;
          end else if (fall) begin
            n.cnt     = 4'h0;
            n.sh      = tx_data;
            n.tx_take = 1'b1;
            n.sda_oe  = ~tx_data[7];
            n.st      = EEP_ST_RDATA;
          end
        end
        default: begin
          n.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // reset lands in standby with the line released
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      r <= '0;                                     // see RULE8
      // idle bus is high; a low reset here would fake an edge
      r.scl_q <= 1'b1;
      r.sda_q <= 1'b1;
    end else if (ce) begin
      r <= n;
    end
  end

  assign bus.sda_dev_o  = 1'b0;                    // see RULE18
  assign bus.sda_dev_oe = r.sda_oe;
  assign rx_valid       = r.rx_valid;
  assign rx_data        = r.rx_data;
  assign tx_take        = r.tx_take;
  assign standby        = (r.st == EEP_ST_STANDBY);
  assign write_busy     = (r.st == EEP_ST_WCYCLE);

endmodule : eep_dev_end

`default_nettype wire

// [eep_host_end.sv]
// Purpose: controller end of the two-wire bus
// Assumes: this end makes scl by dividing clk_sys
// Notes:   one command at a time; every command ends in rsp_valid
`timescale 1ns/1ps
`default_nettype none

module eep_host_end
  import eep_pkg::*;
(
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   resetn,
  input  wire logic                   ce,
  // two-wire bus
  eep_bus_if.host                     bus,
  // commands
  input  wire logic                   cmd_valid,
  input  wire eep_cmd_type            cmd_kind,
  input  wire logic [`EEP_WORD_W-1:0] cmd_data,
  input  wire logic                   cmd_ack,
  output logic                        cmd_ready,
  // responses
  output logic                        rsp_valid,
  output logic      [`EEP_WORD_W-1:0] rsp_data,
  output logic                        rsp_nack
);

  localparam logic [`EEP_QTR_CNT_W-1:0] QTR_LAST =
    `EEP_QTR_CNT_W'(`EEP_SCL_QTR_CYC - 1);

  eep_host_reg_type r;
  eep_host_reg_type n;
  logic             sda;
  logic             tick;

  eep_pin_filter #(
    .W (1)
  ) u_filt (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .ce      (ce),
    .pin_in  (bus.sda_in),
    .level   (sda)
  );

  assign tick      = (r.qcnt == QTR_LAST);
  assign cmd_ready = (r.st == EEP_H_IDLE);

  always_comb begin
    n           = r;
    n.rsp_valid = 1'b0;
    n.qcnt      = tick ? '0 : r.qcnt + 1'b1;
    if (tick) begin
      n.phase = r.phase + 2'h1;
    end
    case (r.st)
      EEP_H_IDLE: begin
        n.qcnt  = '0;
        n.phase = 2'h0;
        n.cnt   = 4'h0;
        if (cmd_valid) begin                       // see RULE4
          case (cmd_kind)
            EEP_CMD_START:   n.st = EEP_H_START;
            EEP_CMD_STOP:    n.st = EEP_H_STOP;
            EEP_CMD_RECOVER: n.st = EEP_H_RECOVER;
            default:         n.st = EEP_H_BYTE;
          endcase
          // ninth bit: release for device ack, or our own ack
          n.sh = (cmd_kind == EEP_CMD_READ)
               ? {8'hFF, ~cmd_ack}
               : {cmd_data, 1'b1};                 // see RULE7 see RULE14
        end
      end
      EEP_H_START: begin
        if (tick) begin
          case (r.phase)
            2'h0:    n.sda_oe = 1'b0;
            2'h1:    n.scl    = 1'b1;
            2'h2:    n.sda_oe = 1'b1;              // see RULE3
            default: begin
              n.scl       = 1'b0;
              n.st        = EEP_H_IDLE;
              n.rsp_valid = 1'b1;
              n.rsp_nack  = 1'b0;
            end
          endcase
        end
      end
      EEP_H_STOP: begin
        if (tick) begin
          case (r.phase)
            2'h0:    n.sda_oe = 1'b1;
            2'h1:    n.scl    = 1'b1;
            2'h2:    n.sda_oe = 1'b0;              // see RULE5
            default: begin
              n.st        = EEP_H_IDLE;
              n.rsp_valid = 1'b1;
              n.rsp_nack  = 1'b0;
            end
          endcase
        end
      end
      EEP_H_BYTE: begin
        if (tick) begin
          case (r.phase)
            2'h0:    n.sda_oe = ~r.sh[8];          // see RULE1
            2'h1:    n.scl    = 1'b1;
            2'h2:    n.rx     = {r.rx[7:0], sda};
            default: begin
              n.scl = 1'b0;
              n.sh  = {r.sh[7:0], 1'b1};
              n.cnt = r.cnt + 4'h1;
              if (r.cnt == 4'h8) begin
                n.st        = EEP_H_IDLE;
                n.rsp_valid = 1'b1;
                n.rsp_data  = r.rx[8:1];
                n.rsp_nack  = r.rx[0];
              end
            end
          endcase
        end
      end
      EEP_H_RECOVER: begin
        if (tick) begin
          case (r.phase)
            2'h0:    n.sda_oe = 1'b0;
            2'h1:    n.scl    = 1'b1;
            2'h2: begin
              // line free while clock high: finish with a start
              if (sda) begin                       // see RULE9
                n.st    = EEP_H_START;
                n.phase = 2'h2;
              end
            end
            default: begin
              n.scl = 1'b0;
              n.cnt = r.cnt + 4'h1;
              if (r.cnt == 4'(`EEP_RECOVER_CLKS - 1)) begin
                n.st        = EEP_H_IDLE;
                n.rsp_valid = 1'b1;
                n.rsp_nack  = 1'b1;
              end
            end
          endcase
        end
      end
      default: n.st = EEP_H_IDLE;
    endcase
  end

  // bus idles with clock high and data released
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      r     <= '0;
      r.scl <= 1'b1;
    end else if (ce) begin
      r <= n;
    end
  end

  assign bus.scl         = r.scl;
  assign bus.sda_host_o  = 1'b0;
  assign bus.sda_host_oe = r.sda_oe;
  assign rsp_valid       = r.rsp_valid;
  assign rsp_data        = r.rsp_data;
  assign rsp_nack        = r.rsp_nack;

endmodule : eep_host_end

`default_nettype wire

// [eep_bus_monitor.sv]
// Purpose: wire-level checker for the two-wire memory front end
// Assumes: strap levels given as parameters, floating counted low
// Notes:   follows bit framing on the raw wire, no filter lag
`timescale 1ns/1ps
`default_nettype none
`include "eep_consts.svh"

module eep_bus_monitor #(
  parameter logic SEL_HIGH = 1'b1,
  parameter logic SEL_LOW  = 1'b0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // wire and drivers
  input wire logic scl,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe,
  input wire logic sda_in,
  // device status
  input wire logic standby,
  input wire logic write_busy
);
  typedef struct packed {
    logic       scl_q;
    logic       sda_q;
    logic [3:0] fc;
    logic       first;
    logic       en;
    logic       rw;
    logic [7:0] addr;
  } eep_mon_reg_type;

  eep_mon_reg_type mon_r;
  eep_mon_reg_type mon_nxt;
  logic            rise;
  logic            start_seen;
  logic            stop_seen;
  logic            match;

  assign rise       = scl & ~mon_r.scl_q;
  assign start_seen = scl & mon_r.scl_q & mon_r.sda_q & ~sda_in;
  assign stop_seen  = scl & mon_r.scl_q & ~mon_r.sda_q & sda_in;
  assign match      = (mon_r.addr[7:3] == `EEP_ADDR_PREFIX) &&
                      (mon_r.addr[2] == SEL_HIGH) && (mon_r.addr[1] == SEL_LOW);

  always_comb begin
    mon_nxt       = mon_r;
    mon_nxt.scl_q = scl;
    mon_nxt.sda_q = sda_in;
    if (start_seen) begin
      mon_nxt.fc    = 4'h0;
      mon_nxt.first = 1'b1;
      mon_nxt.en    = 1'b0;
    end else if (stop_seen) begin
      mon_nxt.en = 1'b0;
    end else if (rise && mon_r.fc == 4'h8) begin
      mon_nxt.fc    = 4'h0;
      mon_nxt.first = 1'b0;
      // a poll during the write cycle must not open a transfer
      if (mon_r.first) begin
        mon_nxt.en = match & ~write_busy;
        mon_nxt.rw = mon_r.addr[0];
      end
    end else if (rise) begin
      mon_nxt.fc   = mon_r.fc + 4'h1;
      mon_nxt.addr = {mon_r.addr[6:0], sda_in};
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mon_r       <= '0;
      mon_r.scl_q <= 1'b1;
      mon_r.sda_q <= 1'b1;
    end else begin
      mon_r <= mon_nxt;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_start;
    !write_busy && start_seen;
  endsequence
  sequence s_stop;
    !write_busy && stop_seen;
  endsequence
  sequence s_ninth;
    rise && mon_r.fc == 4'h8 && !write_busy;
  endsequence

  chk_dev_only_low:
  assert property (sda_dev_oe |-> !sda_dev_o)
    else $error("device drives data high");
  chk_dev_edge_low:
  assert property ($changed(sda_dev_oe) |-> !scl && !$past(scl))
    else $error("device data moved with clock high");
  chk_start_wakes:
  assert property (s_start |-> ##[1:8] !standby)
    else $error("start not taken");
  chk_stop_idle:
  assert property (s_stop |-> ##[1:8] (standby || write_busy))
    else $error("stop did not end transfer");
  chk_addr_ack:
  assert property (s_ninth and mon_r.first |-> sda_dev_oe == match)
    else $error("address acknowledge wrong");
  chk_word_ack:
  assert property (s_ninth and !mon_r.first && mon_r.en && !mon_r.rw
                   |-> sda_dev_oe)
    else $error("written word not acknowledged");
  chk_read_free:
  assert property (s_ninth and !mon_r.first && mon_r.en && mon_r.rw
                   |-> !sda_dev_oe)
    else $error("device held line in read ack slot");
  chk_busy_silent:
  assert property (write_busy |-> !sda_dev_oe)
    else $error("device drove during write cycle");
  chk_busy_end:
  assert property ($fell(write_busy) |-> standby)
    else $error("no standby after write cycle");
endmodule : eep_bus_monitor

`default_nettype wire

// [tb_serial_eeprom_bus_slave_front_end.sv]
// Purpose: bench joining controller end and memory end
// Assumes: controller serial clock fixed at 4 us per bit
// Notes:   write cycle shortened by parameter to keep the run short
`timescale 1ns/1ps
`default_nettype none
`include "eep_consts.svh"

module tb_serial_eeprom_bus_slave_front_end
  import eep_pkg::*;
();
  localparam int unsigned TWR      = 13000;
  localparam int          WAIT_MAX = 30000;

  logic        clk_sys;
  logic        resetn;
  logic        ce;
  logic        low_grade;
  logic        cmd_valid;
  eep_cmd_type cmd_kind;
  logic [7:0]  cmd_data;
  logic        cmd_ack;
  logic        cmd_ready;
  logic        rsp_valid;
  logic [7:0]  rsp_data;
  logic        rsp_nack;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic [7:0]  tx_data;
  logic        tx_take;
  logic        standby;
  logic        write_busy;
  logic [7:0]  rx_last;
  int          rx_cnt;
  int          take_cnt;
  int          busy_cnt;
  int          mismatches;
  int          checks;

  eep_bus_if eep_bus_if_inst ();

  eep_host_end eep_host_end_inst (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .ce        (ce),
    .bus       (eep_bus_if_inst),
    .cmd_valid (cmd_valid),
    .cmd_kind  (cmd_kind),
    .cmd_data  (cmd_data),
    .cmd_ack   (cmd_ack),
    .cmd_ready (cmd_ready),
    .rsp_valid (rsp_valid),
    .rsp_data  (rsp_data),
    .rsp_nack  (rsp_nack)
  );

  // floating low strap must read as zero
  eep_dev_end #(
    .TWR_LOW_CYC (2 * TWR),
    .TWR_STD_CYC (TWR)
  ) eep_dev_end_inst (
    .clk_sys          (clk_sys),
    .resetn           (resetn),
    .ce               (ce),
    .bus              (eep_bus_if_inst),
    .select_pin_high  (1'b1),
    .select_pin_low   (1'bz),
    .low_supply_grade (low_grade),
    .rx_valid         (rx_valid),
    .rx_data          (rx_data),
    .tx_data          (tx_data),
    .tx_take          (tx_take),
    .standby          (standby),
    .write_busy       (write_busy)
  );

  eep_bus_monitor #(
    .SEL_HIGH (1'b1),
    .SEL_LOW  (1'b0)
  ) eep_bus_monitor_inst (
    .clk_sys    (clk_sys),
    .resetn     (resetn),
    .scl        (eep_bus_if_inst.scl),
    .sda_dev_o  (eep_bus_if_inst.sda_dev_o),
    .sda_dev_oe (eep_bus_if_inst.sda_dev_oe),
    .sda_in     (eep_bus_if_inst.sda_in),
    .standby    (standby),
    .write_busy (write_busy)
  );

  always #2 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    if (rx_valid === 1'b1) begin
      rx_cnt  <= rx_cnt + 1;
      rx_last <= rx_data;
    end
    if (tx_take === 1'b1) take_cnt <= take_cnt + 1;
    if (write_busy === 1'b1) busy_cnt <= busy_cnt + 1;
  end

  task automatic fail(input string msg);
    mismatches++;
    $display("MISMATCH %0t %s", $time, msg);
  endtask : fail

  task automatic cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) fail("flag");
  endtask : cmp_bit

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) fail("byte");
  endtask : cmp_byte

  task automatic cmp_cnt(input int got, input int exp);
    checks++;
    if (got != exp) fail("count");
  endtask : cmp_cnt

  task automatic run_cmd(input eep_cmd_type k, input logic [7:0] d,
                         input logic a);
    int n;
    n = 0;
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_kind  <= k;
    cmd_data  <= d;
    cmd_ack   <= a;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (rsp_valid !== 1'b1 && n < WAIT_MAX);
    if (n >= WAIT_MAX) fail("no response");
  endtask : run_cmd

  task automatic t_idle();
    cmp_bit(standby, 1'b1);
    cmp_bit(write_busy, 1'b0);
    run_cmd(EEP_CMD_RECOVER, 8'h00, 1'b0);
    cmp_bit(rsp_nack, 1'b0);
  endtask : t_idle

  task automatic t_strap_miss();
    run_cmd(EEP_CMD_START, 8'h00, 1'b0);
    run_cmd(EEP_CMD_WRITE, 8'hA6, 1'b0);
    cmp_bit(rsp_nack, 1'b1);
    cmp_bit(standby, 1'b1);
    run_cmd(EEP_CMD_STOP, 8'h00, 1'b0);
  endtask : t_strap_miss

  task automatic t_read();
    @(posedge clk_sys);
    tx_data <= 8'hC3;
    run_cmd(EEP_CMD_START, 8'h00, 1'b0);
    run_cmd(EEP_CMD_WRITE, 8'hA5, 1'b0);
    cmp_bit(rsp_nack, 1'b0);
    run_cmd(EEP_CMD_READ, 8'h00, 1'b0);
    cmp_byte(rsp_data, 8'hC3);
    cmp_bit(rsp_nack, 1'b1);
    cmp_cnt(take_cnt, 1);
    run_cmd(EEP_CMD_STOP, 8'h00, 1'b0);
    cmp_bit(standby, 1'b1);
  endtask : t_read

  task automatic t_write();
    logic [7:0] words [3] = '{8'h12, 8'h34, 8'h9C};
    int         n;
    run_cmd(EEP_CMD_START, 8'h00, 1'b0);
    run_cmd(EEP_CMD_WRITE, 8'hA4, 1'b0);
    cmp_bit(rsp_nack, 1'b0);
    foreach (words[i]) begin
      run_cmd(EEP_CMD_WRITE, words[i], 1'b0);
      cmp_bit(rsp_nack, 1'b0);
      cmp_byte(rx_last, words[i]);
    end
    cmp_cnt(rx_cnt, 3);
    run_cmd(EEP_CMD_STOP, 8'h00, 1'b0);
    cmp_bit(write_busy, 1'b1);
    // polling while busy must go unanswered
    run_cmd(EEP_CMD_START, 8'h00, 1'b0);
    run_cmd(EEP_CMD_WRITE, 8'hA4, 1'b0);
    cmp_bit(rsp_nack, 1'b1);
    run_cmd(EEP_CMD_STOP, 8'h00, 1'b0);
    // a frozen clock enable must stretch the write cycle
    @(posedge clk_sys);
    ce <= 1'b0;
    repeat (100) @(posedge clk_sys);
    ce <= 1'b1;
    cmp_bit(write_busy, 1'b1);
    n = 0;
    while (write_busy === 1'b1 && n < TWR) begin
      @(negedge clk_sys);
      n++;
    end
    cmp_cnt(busy_cnt, TWR + 100);
    cmp_bit(standby, 1'b1);
  endtask : t_write

  task automatic test_done();
    if (mismatches == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  initial begin
    clk_sys    = 1'b0;
    resetn     = 1'b0;
    ce         = 1'b1;
    low_grade  = 1'b0;
    cmd_valid  = 1'b0;
    cmd_kind   = EEP_CMD_START;
    cmd_data   = 8'h00;
    cmd_ack    = 1'b0;
    tx_data    = 8'h00;
    rx_last    = 8'h00;
    rx_cnt     = 0;
    take_cnt   = 0;
    busy_cnt   = 0;
    mismatches = 0;
    checks     = 0;
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    t_idle();
    t_strap_miss();
    t_read();
    t_write();
    test_done();
  end

  // eight words, starts, stops and the write cycle need about 340 us
  initial begin
    #440000;
    fail("timeout");
    test_done();
  end
endmodule : tb_serial_eeprom_bus_slave_front_end

`default_nettype wire
